// ### hdl/dwr_pkg.sv
package dwr_pkg;

	// ***********************************
	// Sizes
	// ***********************************
	localparam int          WIPER_W      = 6;
	localparam int          TAP_N        = 64;
	localparam int          NUM_CH       = 2;
	localparam int          NUM_STORED   = 4;
	localparam int          ADDR_W       = 4;
	localparam int          BYTE_W       = 8;
	localparam int          SYNC_W       = 7;

	// ***********************************
	// Serial byte layout
	// ***********************************
	// Device type code, value arbitrary
	localparam logic [2:0]  DEV_TYPE     = 3'h5;
	localparam int          ADR_TYPE_MSB = 7;
	localparam int          ADR_TYPE_LSB = 5;
	localparam int          ADR_SEL_MSB  = 4;
	localparam int          ADR_SEL_LSB  = 1;
	localparam int          ADR_RW_BIT   = 0;
	localparam int          INS_OP_MSB   = 7;
	localparam int          INS_OP_LSB   = 6;
	localparam int          INS_CH_BIT   = 4;
	localparam int          INS_IDX_MSB  = 3;
	localparam int          INS_IDX_LSB  = 2;
	localparam logic [1:0]  OP_SEL_WIPER = 2'h0;
	localparam logic [1:0]  OP_SEL_STORE = 2'h1;
	localparam logic [1:0]  OP_WR_WIPER  = 2'h2;
	localparam logic [1:0]  OP_WR_STORE  = 2'h3;
	localparam logic [3:0]  ACK_BIT      = 4'h8;
	localparam logic [1:0]  RECALL_IDX   = 2'h0;

	// ***********************************
	// Reset values
	// ***********************************
	localparam logic [WIPER_W-1:0] WIPER_RST = 6'h00;
	localparam logic [TAP_N-1:0]   TAP_ONE   = 64'h0000_0000_0000_0001;
	localparam logic [BYTE_W-1:0]  BYTE_RST  = 8'h00;

	// ***********************************
	// Types
	// ***********************************
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_INSTR, ST_WRITE, ST_READ, ST_IGNORE} dwr_state_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} dwr_serial_t;
	typedef struct packed {
		logic sda_out;
		logic sda_oe;
	} dwr_drive_t;
	typedef logic [TAP_N-1:0]   dwr_tap_t;
	typedef logic [WIPER_W-1:0] dwr_wiper_t;

endpackage

// ### hdl/dwr_sync.sv
module dwr_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_reg;

	// ***********************************
	// Two-stage synchroniser
	// ***********************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			meta_reg <= '1;
			dout     <= '1;
		end
		else
		begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end

endmodule

// ### hdl/dwr_core.sv
module dwr_core #(
	parameter int STORED = dwr_pkg::NUM_STORED
) (
	input  wire logic                                core_clk,
	input  wire logic                                rst_b,
	input  wire dwr_pkg::dwr_serial_t                serial_in,
	output dwr_pkg::dwr_drive_t                      sda_drive,
	input  wire logic                                addr_select_bit0,
	input  wire logic                                addr_select_bit1,
	input  wire logic                                addr_select_bit2,
	input  wire logic                                addr_select_bit3,
	input  wire logic                                write_guard,
	output dwr_pkg::dwr_wiper_t [dwr_pkg::NUM_CH-1:0] wiper_position,
	output dwr_pkg::dwr_tap_t   [dwr_pkg::NUM_CH-1:0] tap_select
);
	import dwr_pkg::*;

	if (STORED < 1 || STORED > NUM_STORED)
	begin : g_chk
		$error("STORED must be 1 to 4");
	end

	logic [SYNC_W-1:0] sync_q;
	logic              scl_s;
	logic              sda_s;
	logic              guard_s;
	logic [ADDR_W-1:0] addr_s;
	logic              scl_d_reg;
	logic              sda_d_reg;
	logic              scl_rise;
	logic              scl_fall;
	logic              start_det;
	logic              stop_det;
	dwr_state_t        state_reg;
	logic [3:0]        bit_cnt_reg;
	logic              ack_phase_reg;
	logic [BYTE_W-1:0] shift_reg;
	logic [BYTE_W-1:0] instr_reg;
	logic [BYTE_W-1:0] tx_reg;
	logic              recall_reg;
	logic              byte_end;
	logic              addr_match;
	logic [1:0]        op;
	logic              ch;
	logic [1:0]        idx;
	logic              idx_ok;
	logic              wiper_wr_en;
	logic              stored_req;
	logic              stored_wr_en;
	logic              ack_now;
	dwr_wiper_t        rd_data;
	dwr_wiper_t        stored_mem [NUM_CH][STORED] = '{default: WIPER_RST};

	// ***********************************
	// Pin sampling and edge finding
	// ***********************************
	dwr_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.din      ({serial_in.scl, serial_in.sda, write_guard, addr_select_bit3,
		            addr_select_bit2, addr_select_bit1, addr_select_bit0}),
		.dout     (sync_q)
	);

	assign scl_s   = sync_q[6];
	assign sda_s   = sync_q[5];
	assign guard_s = sync_q[4];
	assign addr_s  = sync_q[3:0];

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_d_reg;
	assign scl_fall  = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	// ***********************************
	// Byte decode
	// ***********************************
	assign byte_end   = scl_fall && bit_cnt_reg == ACK_BIT && !ack_phase_reg
	                    && state_reg != ST_READ;
	assign addr_match = shift_reg[ADR_TYPE_MSB:ADR_TYPE_LSB] == DEV_TYPE
	                    && shift_reg[ADR_SEL_MSB:ADR_SEL_LSB] == addr_s;
	assign op         = instr_reg[INS_OP_MSB:INS_OP_LSB];
	assign ch         = instr_reg[INS_CH_BIT];
	assign idx        = instr_reg[INS_IDX_MSB:INS_IDX_LSB];
	assign idx_ok     = 32'(idx) < STORED;
	assign wiper_wr_en  = byte_end && state_reg == ST_WRITE && op == OP_WR_WIPER;
	assign stored_req   = byte_end && state_reg == ST_WRITE && op == OP_WR_STORE && idx_ok;
	assign stored_wr_en = stored_req && guard_s;
	assign rd_data = (op == OP_SEL_STORE && idx_ok) ? stored_mem[ch][idx] : wiper_position[ch];

	always_comb
	begin
		unique case (state_reg)
			ST_ADDR:  ack_now = addr_match;
			ST_INSTR: ack_now = 1'b1;
			ST_WRITE: ack_now = op == OP_WR_WIPER || stored_wr_en;
			default:  ack_now = 1'b0;
		endcase
	end

	// ***********************************
	// Serial protocol engine
	// ***********************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			state_reg     <= ST_IDLE;
			bit_cnt_reg   <= 4'h0;
			ack_phase_reg <= 1'b0;
			shift_reg     <= BYTE_RST;
			instr_reg     <= BYTE_RST;
			tx_reg        <= BYTE_RST;
			sda_drive     <= '{sda_out: 1'b0, sda_oe: 1'b0};
		end
		else if (start_det)
		begin
			state_reg        <= ST_ADDR;
			bit_cnt_reg      <= 4'h0;
			ack_phase_reg    <= 1'b0;
			sda_drive.sda_oe <= 1'b0;
		end
		else if (stop_det)
		begin
			state_reg        <= ST_IDLE;
			ack_phase_reg    <= 1'b0;
			sda_drive.sda_oe <= 1'b0;
		end
		else if (state_reg != ST_IDLE && state_reg != ST_IGNORE)
		begin
			if (scl_rise)
			begin
				if (bit_cnt_reg != ACK_BIT)
				begin
					shift_reg   <= {shift_reg[BYTE_W-2:0], sda_s};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
				else
				begin
					bit_cnt_reg <= 4'h0;
					if (state_reg == ST_READ)
					begin
						if (sda_s)
							state_reg <= ST_IGNORE;
						else
						begin
							ack_phase_reg <= 1'b1;
							tx_reg        <= {2'h0, rd_data};
						end
					end
				end
			end
			else if (scl_fall)
			begin
				if (byte_end)
				begin
					ack_phase_reg    <= 1'b1;
					sda_drive.sda_oe <= ack_now;
					unique case (state_reg)
						ST_ADDR:
						begin
							if (!addr_match)
								state_reg <= ST_IGNORE;
							else if (shift_reg[ADR_RW_BIT])
							begin
								state_reg <= ST_READ;
								tx_reg    <= {2'h0, rd_data};
							end
							else
								state_reg <= ST_INSTR;
						end
						ST_INSTR:
						begin
							instr_reg <= shift_reg;
							state_reg <= ST_WRITE;
						end
						default:
							state_reg <= state_reg;
					endcase
				end
				else if (ack_phase_reg || (state_reg == ST_READ && bit_cnt_reg != ACK_BIT))
				begin
					ack_phase_reg    <= 1'b0;
					sda_drive.sda_oe <= state_reg == ST_READ && !tx_reg[BYTE_W-1];
					if (state_reg == ST_READ)
						tx_reg <= {tx_reg[BYTE_W-2:0], 1'b0};
				end
				else
					sda_drive.sda_oe <= 1'b0;
			end
		end
		else
			sda_drive.sda_oe <= 1'b0;
	end

	// ***********************************
	// Wiper registers and recall
	// ***********************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			recall_reg <= 1'b1;
		else
			recall_reg <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			wiper_position <= '{default: WIPER_RST};
		else if (recall_reg)
		begin
			for (int c = 0; c < NUM_CH; c++)
				wiper_position[c] <= stored_mem[c][RECALL_IDX];
		end
		else if (wiper_wr_en)
			wiper_position[ch] <= shift_reg[WIPER_W-1:0];
	end

	// ***********************************
	// Stored settings, kept across reset
	// ***********************************
	always_ff @(posedge core_clk)
	begin
		if (stored_wr_en)
			stored_mem[ch][idx] <= shift_reg[WIPER_W-1:0];
	end

	// ***********************************
	// Tap decode per channel
	// ***********************************
	for (genvar c = 0; c < NUM_CH; c++)
	begin : g_tap
		always_ff @(posedge core_clk)
		begin
			if (!rst_b)
				tap_select[c] <= TAP_ONE;
			else
				tap_select[c] <= TAP_ONE << wiper_position[c];
		end
	end

	// ***********************************
	// Checks
	// ***********************************
	chk_tap_onehot: assert property (@(posedge core_clk) disable iff (!rst_b)
		$onehot(tap_select[0]) && $onehot(tap_select[1]))
		else $error("tap select not one-hot");

	chk_tap_ends: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(rst_b) && wiper_position[0] == 6'h3F |=> tap_select[0][TAP_N-1])
		else $error("top wiper value not at high end tap");

	chk_stored_lands: assert property (@(posedge core_clk) disable iff (!rst_b)
		stored_wr_en |=> stored_mem[$past(ch)][$past(idx)] == $past(shift_reg[WIPER_W-1:0]))
		else $error("stored setting write lost");

	chk_recall_load: assert property (@(posedge core_clk) disable iff (!rst_b)
		recall_reg |=> wiper_position[1] == $past(stored_mem[1][0])
		               && wiper_position[0] == $past(stored_mem[0][0]))
		else $error("power-up recall missing");

	chk_wiper_cause: assert property (@(posedge core_clk) disable iff (!rst_b)
		!recall_reg && !wiper_wr_en |=> $stable(wiper_position))
		else $error("wiper changed without bus write");

	chk_guard_block: assert property (@(posedge core_clk) disable iff (!rst_b)
		stored_req && !guard_s |-> !stored_wr_en ##1 !sda_drive.sda_oe)
		else $error("guarded stored write not blocked");

	chk_guard_open: assert property (@(posedge core_clk) disable iff (!rst_b)
		stored_req && guard_s |-> stored_wr_en ##1 sda_drive.sda_oe)
		else $error("unguarded stored write refused");

	chk_addr_miss: assert property (@(posedge core_clk) disable iff (!rst_b)
		byte_end && state_reg == ST_ADDR && !addr_match
		|=> !sda_drive.sda_oe && state_reg == ST_IGNORE)
		else $error("answered foreign address");

	chk_open_drain: assert property (@(posedge core_clk) disable iff (!rst_b)
		!sda_drive.sda_out)
		else $error("data line driven high");

	chk_oe_scl_low: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(sda_drive.sda_oe) |-> !$past(scl_s))
		else $error("data line taken while clock high");

endmodule

// ### dv/dwr_master.sv
module dwr_master (
	input  wire logic sda_oe,
	output logic      scl,
	output logic      sda
);
	timeunit 1ns;
	timeprecision 10ps;

	// ***********************************
	// Open-drain line with pull-up
	// ***********************************
	logic sda_m;

	assign sda = sda_m & ~sda_oe;

	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	// ***********************************
	// Bit, frame and byte cycles
	// ***********************************
	task automatic bit_io(input logic b, output logic r);
		#43.75 sda_m = b;
		#18.75 scl = 1'b1;
		#31.25 r = sda;
		#31.25 scl = 1'b0;
	endtask

	task automatic start();
		#43.75 sda_m = 1'b1;
		#18.75 scl = 1'b1;
		#31.25 sda_m = 1'b0;
		#31.25 scl = 1'b0;
	endtask

	task automatic stop();
		#43.75 sda_m = 1'b0;
		#18.75 scl = 1'b1;
		#31.25 sda_m = 1'b1;
		#31.25;
	endtask

	task automatic wb(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	task automatic rb(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule

// ### dv/dual_wiper_register_control_tb.sv
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end

module dual_wiper_register_control_tb;
	timeunit 1ns;
	timeprecision 10ps;
	import dwr_pkg::*;

	logic                      core_clk = 1'b0;
	logic                      rst_b    = 1'b0;
	logic                      wg       = 1'b1;
	logic                      armed    = 1'b0;
	logic [3:0]                sa;
	logic [31:0]               lfsr     = 32'h0001_0964;
	int                        mismatches = 0;
	int                        n_tests  = 0;
	int                        cyc      = 0;
	wire                       scl_w;
	wire                       sda_w;
	wire dwr_serial_t          ser;
	dwr_drive_t                drv;
	dwr_wiper_t [NUM_CH-1:0]   wip, exp_w, prev, ew;
	dwr_tap_t   [NUM_CH-1:0]   tap;
	dwr_wiper_t [NUM_CH-1:0]   q[$];
	logic                      a;
	logic [7:0]                rd;
	dwr_wiper_t                s0;

	assign ser = {scl_w, sda_w};
	always #5 core_clk = ~core_clk;

	dwr_master m (.sda_oe(drv.sda_oe), .scl(scl_w), .sda(sda_w));
	dwr_core dut (.core_clk(core_clk), .rst_b(rst_b), .serial_in(ser), .sda_drive(drv),
		.addr_select_bit0(sa[0]), .addr_select_bit1(sa[1]), .addr_select_bit2(sa[2]),
		.addr_select_bit3(sa[3]), .write_guard(wg), .wiper_position(wip),
		.tap_select(tap));

	// ***********************************
	// Helpers
	// ***********************************
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	function automatic logic [7:0] op_byte(input logic [1:0] op, input logic c,
		input logic [1:0] idx);
		return {op, 1'b0, c, idx, 2'h0};
	endfunction

	task automatic summarize();
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic rst_pulse();
		@(negedge core_clk);
		rst_b = 1'b0;
		repeat (16) @(negedge core_clk);
		rst_b = 1'b1;
		#0.3;
	endtask

	task automatic xfer(input logic [7:0] ins, input logic [7:0] d, input logic ea);
		m.start();
		m.wb({3'h5, sa, 1'b0}, a);
		`CHK("adr_ack", 1'b1, a)
		m.wb(ins, a);
		`CHK("ins_ack", 1'b1, a)
		m.wb(d, a);
		`CHK("dat_ack", ea, a)
		m.stop();
	endtask

	task automatic rd_chk(input logic [7:0] ins, input logic [7:0] e);
		m.start();
		m.wb({3'h5, sa, 1'b0}, a);
		m.wb(ins, a);
		m.start();
		m.wb({3'h5, sa, 1'b1}, a);
		`CHK("rd_ack", 1'b1, a)
		m.rb(1'b1, rd);
		`CHK("rd_dat", e, rd)
		m.stop();
	endtask

	task automatic ww(input logic c, input dwr_wiper_t v);
		exp_w[c] = (v === exp_w[c]) ? ~v : v;
		q.push_back(exp_w);
		xfer(op_byte(2'h2, c, 2'h0), {2'h0, exp_w[c]}, 1'b1);
	endtask

	// ***********************************
	// Output watcher
	// ***********************************
	always @(posedge core_clk)
	begin
		prev <= wip;
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			mismatches++;
			summarize();
		end
		else if (rst_b && armed && wip !== prev)
		begin
			ew = q.pop_front();
			`CHK("wiper", ew, wip)
			`CHK("sda_out", 1'b0, drv.sda_out)
			@(negedge core_clk);
			for (int i = 0; i < NUM_CH; i++)
				`CHK("tap", TAP_ONE << ew[i], tap[i])
		end
	end

	// ***********************************
	// Scenarios
	// ***********************************
	initial
	begin
		lfsr = nx(lfsr);
		sa = lfsr[3:0];
		s0 = {1'b1, lfsr[8:5], 1'b0};
		rst_pulse();
		xfer(op_byte(2'h3, 1'b0, 2'h0), {2'h0, s0}, 1'b1);
		xfer(op_byte(2'h3, 1'b1, 2'h0), 8'h2A, 1'b1);
		xfer(op_byte(2'h3, 1'b1, 2'h3), 8'h15, 1'b1);
		rd_chk(op_byte(2'h1, 1'b1, 2'h3), 8'h15);
		exp_w = {6'h2A, s0};
		q.push_back(exp_w);
		armed = 1'b1;
		rst_pulse();
		for (int i = 0; i < 6; i++)
		begin
			lfsr = nx(lfsr);
			ww(i[0], (i < 2) ? 6'h00 : (i > 3) ? 6'h3F : lfsr[5:0]);
			rd_chk(op_byte(2'h0, i[0], 2'h0), {2'h0, exp_w[i[0]]});
		end
		m.start();
		m.wb({3'h5, ~sa, 1'b0}, a);
		`CHK("foreign_adr", 1'b0, a)
		m.wb(op_byte(2'h2, 1'b0, 2'h0), a);
		m.wb(8'h09, a);
		m.stop();
		@(negedge core_clk);
		wg = 1'b0;
		#0.3;
		xfer(op_byte(2'h3, 1'b0, 2'h0), 8'h07, 1'b0);
		ww(1'b0, 6'h11);
		@(negedge core_clk);
		wg = 1'b1;
		exp_w = {6'h2A, s0};
		q.push_back(exp_w);
		rst_pulse();
		repeat (4) @(negedge core_clk);
		`CHK("queue", 0, q.size())
		summarize();
	end
endmodule
